// >>> verilog/fspg_pkg.sv
// Package: register map, field positions and carrier types of the flash status/protection guard
`default_nettype none
package fspg_pkg;
  // ****************************************
  // Register map (word indices from byte address bits 5:2, one word each)
  // ****************************************
  localparam logic [3:0] FSPG_IDX_PROT   = 4'h4;  // Protection configuration index
  localparam logic [3:0] FSPG_IDX_STAT   = 4'h5;  // Status flags index
  localparam logic [3:0] FSPG_IDX_CNFG   = 4'h3;  // Interrupt enable config index
  localparam logic [3:0] FSPG_IDX_CTRL   = 4'h8;  // Mode and engine status index
  localparam int         FSPG_ADDR_W     = 6;     // Byte address width
  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int FSPG_B_BUF_EMPTY = 7;  // Buffer empty
  localparam int FSPG_B_COMPLETE  = 6;  // Queue complete
  localparam int FSPG_B_PROTECT_VIOLATION_FLAG     = 5;  // Protection violation
  localparam int FSPG_B_ACCESS_ERROR_FLAG    = 4;  // Access error
  localparam int FSPG_B_BLANK     = 2;  // Erased verified
  localparam int FSPG_B_FAIL      = 1;  // Verify failed
  localparam int FSPG_B_IDLE      = 0;  // Operation idle
  // ****************************************
  // Protection config fields
  // ****************************************
  localparam int FSPG_P_OPEN   = 7;  // Open select
  localparam int FSPG_P_HDIS   = 5;  // High range disable
  localparam int FSPG_P_HS     = 3;  // High size low bit (2 bits)
  localparam int FSPG_P_LDIS   = 2;  // Low range disable
  localparam int FSPG_P_LS     = 0;  // Low size low bit (2 bits)
  // ****************************************
  // Config fields
  // ****************************************
  localparam int FSPG_C_BE_IE  = 7;  // Buffer empty irq enable
  localparam int FSPG_C_CC_IE  = 6;  // Complete irq enable
  localparam int FSPG_C_SPEC   = 0;  // Special mode (control reg)
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] FSPG_PROT_RST = 8'hff;  // Protection default: none
  localparam logic [7:0] FSPG_CNFG_RST = 8'h00;  // Interrupts disabled
  // Events from the command sequencer, all one-cycle pulses
  typedef struct packed {
    logic seq_word_wr;   // Aligned word written to flash space
    logic seq_abort;     // Sequence violation
    logic illegal_cmd;   // Illegal command bits
    logic cpu_stop;      // CPU stop instruction
    logic prot_hit;      // Program/erase hit protected area
    logic buf_freed;     // Buffers released to software
    logic all_done;      // Active and pending commands finished
    logic verify_blank;  // Erase verify: erased
    logic verify_dirty;  // Erase verify: not erased
  } fspg_evt_t;
endpackage
`default_nettype wire

// >>> verilog/fspg_prot_guard.sv
// Protection transition guard: scenario mapping and transition legality
`default_nettype none
module fspg_prot_guard
  import fspg_pkg::*;
(
  input  wire logic [7:0] cur_i,      // Protection in force
  input  wire logic [7:0] req_i,      // Requested value
  output logic      [7:0] next_o,     // Value to store
  output logic            allowed_o   // Transition legal
);
  // ****************************************
  // Scenario mapping
  // ****************************************
  // Open/hdis/ldis to scenario 0..7
  function automatic logic [2:0] scen(input logic [7:0] v);
    logic [2:0] k;
    k = {v[FSPG_P_OPEN], v[FSPG_P_HDIS], v[FSPG_P_LDIS]};
    case (k)
      3'h7:    scen = 3'h7;  // No protection
      3'h6:    scen = 3'h6;  // Protect low
      3'h5:    scen = 3'h5;  // Protect high
      3'h4:    scen = 3'h4;  // Protect high and low
      3'h3:    scen = 3'h0;  // Full array
      3'h1:    scen = 3'h1;  // Unprotected high
      3'h2:    scen = 3'h2;  // Unprotected low
      default: scen = 3'h3;  // Unprotected high and low
    endcase
  endfunction

  logic [2:0] from_s;  // Current scenario
  logic [2:0] to_s;    // Requested scenario
  logic [7:0] ok_row;  // Allowed targets of current
  logic [7:0] merged;  // Request with locked size fields

  always_comb begin
    from_s = scen(cur_i);
    to_s   = scen(req_i);
    case (from_s)  // Rows indexed by target bit
      3'h0:    ok_row = 8'h0f;
      3'h1:    ok_row = 8'h0a;
      3'h2:    ok_row = 8'h0c;
      3'h3:    ok_row = 8'h08;
      3'h4:    ok_row = 8'h18;
      3'h5:    ok_row = 8'h3c;
      3'h6:    ok_row = 8'h5a;
      default: ok_row = 8'hff;
    endcase
    allowed_o = ok_row[to_s];
    merged = req_i;
    // Size fields only move while their range is disabled
    if (!cur_i[FSPG_P_HDIS]) begin
      merged[FSPG_P_HS+1:FSPG_P_HS] = cur_i[FSPG_P_HS+1:FSPG_P_HS];
    end
    if (!cur_i[FSPG_P_LDIS]) begin
      merged[FSPG_P_LS+1:FSPG_P_LS] = cur_i[FSPG_P_LS+1:FSPG_P_LS];
    end
    next_o = allowed_o ? merged : cur_i;
  end
endmodule
`default_nettype wire

// >>> verilog/fspg_top.sv
// Flash status flags and protection guard with Avalon-MM register slave
`default_nettype none
// Functional notes
// - Protection moves per transition table (full array may go to scenarios 1-3); illegal writes discarded
// - Protection read returns scenario in force
// - Transitions from scenarios zero to three
// - Transitions from scenarios four to seven
// - Normal mode status access; others read zero
// - Special mode: fail writable, idle readonly
// - Buffer empty flag, write one clears
// - Zero to buffer flag mid-sequence aborts, errors
// - Buffer empty with enable raises interrupt
// - Complete flag after all commands finish
// - Complete with enable raises interrupt
// - Protection violation flag, write one clears
// - Error flags block new command launch
// - Access error sources, write one clears
// - Erased verified flag, cleared on launch
// - Verify failed flag in special mode
// - Idle flag low while operation active
// - High size writable only when disabled
// - Low size writable only when disabled
module fspg_top
  import fspg_pkg::*;
(
  input  wire logic                   ref_clk_i,          // Bus clock, 10 MHz
  input  wire logic                   rst_n_i,            // Sync reset, active low
  input  wire logic [FSPG_ADDR_W-1:0] avs_address_i,      // Byte address
  input  wire logic                   avs_read_i,         // Read strobe
  input  wire logic                   avs_write_i,        // Write strobe
  input  wire logic [31:0]            avs_writedata_i,    // Write data
  input  wire logic [3:0]             avs_byteenable_i,   // Byte enables
  output logic      [31:0]            avs_readdata_o,     // Read data
  output logic                        avs_waitrequest_o,  // Wait request
  input  wire fspg_evt_t              evt_i,              // Sequencer events
  input  wire logic                   op_active_i,        // Operation running
  output logic                        launch_ok_o,        // Launch permitted
  output logic                        seq_abort_o,        // Abort command sequence
  output logic                        launch_o,           // Command launched
  output logic                        irq_o               // Interrupt request
);
  // ****************************************
  // State
  // ****************************************
  logic [7:0] prot_q;      // Protection in force
  logic [7:0] cnfg_q;      // Interrupt enables
  logic       spec_q;      // Special mode
  logic       be_q;        // Buffer empty
  logic       cc_q;        // Queue complete
  logic       pv_q;        // Protection violation
  logic       ae_q;        // Access error
  logic       blank_q;     // Erased verified
  logic       fail_q;      // Verify failed
  logic       in_seq_q;    // Word written, launch pending
  logic       ack_q;       // Bus answer phase
  logic [7:0] prot_next;   // Guarded protection value
  logic       prot_ok;     // Guard verdict
  logic       idle_w;      // Idle indication

  // ****************************************
  // Bus decode
  // ****************************************
  logic [3:0] idx;         // Word index
  logic       req;         // Request in its accept cycle
  logic       wr;          // Write accepted
  logic [7:0] wd;          // Low byte of write data
  logic       lane0;       // Low byte lane enabled
  assign idx   = avs_address_i[FSPG_ADDR_W-1:2];
  assign req   = (avs_read_i || avs_write_i) && !ack_q;
  assign wr    = avs_write_i && req;
  assign lane0 = avs_byteenable_i[0];
  assign wd    = avs_writedata_i[7:0];

  // Decode write to a given register index
  function automatic logic hit(input logic [3:0] a, input logic [3:0] b, input logic w);
    hit = w && (a == b);
  endfunction

  logic stat_wr;           // Status written
  logic be_clr_wr;         // One written to buffer empty
  logic be_zero_wr;        // Zero written to buffer empty
  logic launch_w;          // Command launches now
  logic blocked;           // Error flags block launch
  assign stat_wr    = hit(idx, FSPG_IDX_STAT, wr) && lane0;
  assign be_clr_wr  = stat_wr && wd[FSPG_B_BUF_EMPTY];
  assign be_zero_wr = stat_wr && !wd[FSPG_B_BUF_EMPTY];
  assign blocked    = pv_q || ae_q || (spec_q && fail_q);
  assign launch_w   = be_clr_wr && in_seq_q && !blocked;

  // Guard against scenario transitions the table forbids
  fspg_prot_guard u_guard (
    .cur_i     (prot_q),
    .req_i     (wd),
    .next_o    (prot_next),
    .allowed_o (prot_ok)
  );

  // ****************************************
  // Bus handshake: one wait cycle per access
  // ****************************************
  // Waitrequest drops in the cycle after the request appears
  // Waitrequest kept in its own flop so the pin never sees decode glitches
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_q             <= req;
      avs_waitrequest_o <= !req;  // Low for exactly the answer cycle
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Protection: only guarded values are ever stored
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prot_q <= FSPG_PROT_RST;
    end else if (hit(idx, FSPG_IDX_PROT, wr) && lane0) begin
      prot_q <= prot_next;
    end
  end

  // Interrupt enables and mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnfg_q <= FSPG_CNFG_RST;
      spec_q <= 1'b0;
    end else begin
      if (hit(idx, FSPG_IDX_CNFG, wr) && lane0) begin
        cnfg_q <= wd & 8'hc0;  // Only enable bits kept
      end
      if (hit(idx, FSPG_IDX_CTRL, wr) && lane0) begin
        spec_q <= wd[FSPG_C_SPEC];
      end
    end
  end

  // ****************************************
  // Sequence tracking
  // ****************************************
  // Open between aligned word write and the next buffer empty write or abort
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      in_seq_q <= 1'b0;
    end else if (evt_i.seq_word_wr) begin
      in_seq_q <= 1'b1;  // A new word wins over closing
    end else if (be_clr_wr || be_zero_wr || evt_i.seq_abort) begin
      in_seq_q <= 1'b0;
    end
  end

  // ****************************************
  // Status flags (set beats clear)
  // ****************************************
  // Buffer empty: write one clears, hardware frees
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      be_q <= 1'b1;
    end else if (evt_i.buf_freed) begin
      be_q <= 1'b1;
    end else if (be_clr_wr) begin
      be_q <= 1'b0;
    end
  end

  // Complete: low while buffers busy, high after all commands end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cc_q <= 1'b1;
    end else if (evt_i.all_done) begin
      cc_q <= 1'b1;
    end else if (!be_q || launch_w) begin
      cc_q <= 1'b0;
    end
  end

  // Protection violation: write one clears
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pv_q <= 1'b0;
    end else if (evt_i.prot_hit) begin
      pv_q <= 1'b1;
    end else if (stat_wr && wd[FSPG_B_PROTECT_VIOLATION_FLAG]) begin
      pv_q <= 1'b0;
    end
  end

  // Access error: sequence, command, stop sources
  logic ae_set;  // Any access error source
  assign ae_set = evt_i.seq_abort || evt_i.illegal_cmd
                  || (evt_i.cpu_stop && !cc_q)
                  || (be_zero_wr && in_seq_q);
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ae_q <= 1'b0;
    end else if (ae_set) begin
      ae_q <= 1'b1;
    end else if (stat_wr && wd[FSPG_B_ACCESS_ERROR_FLAG]) begin
      ae_q <= 1'b0;
    end
  end

  // Erased verified: cleared when a valid sequence launches
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      blank_q <= 1'b0;
    end else if (evt_i.verify_blank) begin
      blank_q <= 1'b1;
    end else if (launch_w) begin
      blank_q <= 1'b0;
    end
  end

  // Verify failed: only in special mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fail_q <= 1'b0;
    end else if (spec_q && evt_i.verify_dirty) begin
      fail_q <= 1'b1;
    end else if (spec_q && stat_wr && wd[FSPG_B_FAIL]) begin
      fail_q <= 1'b0;
    end
  end

  // ****************************************
  // Outputs toward sequencer and CPU
  // ****************************************
  assign idle_w = !op_active_i;

  // Registered control outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      launch_ok_o <= 1'b0;
      seq_abort_o <= 1'b0;
      launch_o    <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      launch_ok_o <= !blocked;
      seq_abort_o <= be_zero_wr && in_seq_q;
      launch_o    <= launch_w;
      irq_o       <= (be_q && cnfg_q[FSPG_C_BE_IE])
                     || (cc_q && cnfg_q[FSPG_C_CC_IE]);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] stat_rd;  // Status as seen by software
  always_comb begin
    stat_rd = 8'h00;
    stat_rd[FSPG_B_BUF_EMPTY] = be_q;
    stat_rd[FSPG_B_COMPLETE]  = cc_q;
    stat_rd[FSPG_B_PROTECT_VIOLATION_FLAG]     = pv_q;
    stat_rd[FSPG_B_ACCESS_ERROR_FLAG]    = ae_q;
    stat_rd[FSPG_B_BLANK]     = blank_q;
    stat_rd[FSPG_B_FAIL]      = spec_q && fail_q;
    stat_rd[FSPG_B_IDLE]      = spec_q && idle_w;
  end

  // Read data latched in the accept cycle; unmapped reads give zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && req) begin
      case (idx)
        FSPG_IDX_PROT: avs_readdata_o <= {24'h00_0000, prot_q};
        FSPG_IDX_STAT: avs_readdata_o <= {24'h00_0000, stat_rd};
        FSPG_IDX_CNFG: avs_readdata_o <= {24'h00_0000, cnfg_q};
        FSPG_IDX_CTRL: avs_readdata_o <= {30'h0000_0000, op_active_i, spec_q};
        default:       avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence stat_clear_wr_s(int b);
    wr && lane0 && idx == FSPG_IDX_STAT && wd[b];
  endsequence
  // Abort: error flag up with one abort pulse, flag still up a cycle on
  sequence abort_seen_s;
    (ae_q && seq_abort_o) ##1 (ae_q && !seq_abort_o);
  endsequence
  // Status read in its accept cycle
  sequence stat_read_s;
    avs_read_i && req && idx == FSPG_IDX_STAT;
  endsequence

  prot_guard_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (hit(idx, FSPG_IDX_PROT, wr) && lane0 && !prot_ok) |=> $stable(prot_q))
    else $error("protection changed on illegal write");
  prot_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(hit(idx, FSPG_IDX_PROT, wr) && lane0) |=> $stable(prot_q))
    else $error("protection changed without write");
  prot_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (avs_read_i && req && idx == FSPG_IDX_PROT) |=> avs_readdata_o[7:0] == prot_q)
    else $error("protection read mismatch");
  be_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (stat_clear_wr_s(FSPG_B_BUF_EMPTY) ##0 !evt_i.buf_freed) |=> !be_q)
    else $error("buffer flag not cleared");
  abort_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (be_zero_wr && in_seq_q) |=> abort_seen_s)
    else $error("abort did not set access error");
  protect_violation_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    evt_i.prot_hit |=> pv_q)
    else $error("violation flag not set");
  launch_blk_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (pv_q || ae_q) |=> !launch_o)
    else $error("launch while error set");
  irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (be_q && cnfg_q[FSPG_C_BE_IE]) |=> irq_o)
    else $error("buffer empty irq missing");
  fail_norm_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !spec_q |-> (stat_rd[FSPG_B_FAIL] == 1'b0 && stat_rd[FSPG_B_IDLE] == 1'b0))
    else $error("fail or idle visible in normal mode");
  // Completion follows the queue, set winning over the busy clear
  cc_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    evt_i.all_done |=> cc_q)
    else $error("complete flag not set");
  cc_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!be_q && !evt_i.all_done) |=> !cc_q)
    else $error("complete flag high while buffers busy");
  irq_cc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cc_q && cnfg_q[FSPG_C_CC_IE]) |=> irq_o)
    else $error("complete irq missing");
  blank_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (launch_w && !evt_i.verify_blank) |=> !blank_q)
    else $error("erased flag kept over launch");
  fail_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (spec_q && evt_i.verify_dirty) |=> fail_q)
    else $error("verify failed flag not set");
  fail_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (stat_clear_wr_s(FSPG_B_FAIL) ##0 !spec_q) |=> $stable(fail_q))
    else $error("fail flag moved in normal mode");
  idle_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (stat_read_s ##0 spec_q) |=> (avs_readdata_o[FSPG_B_IDLE] != $past(op_active_i)))
    else $error("idle flag read wrong");
  ae_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ae_set |=> ae_q)
    else $error("access error not set");
endmodule
`default_nettype wire

// >>> sim/fspg_tb.sv
// Self-checking bench for the flash status flags and protection guard
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
`define CHKS(nm, ex, got) begin @(negedge ref_clk_i); `CHK(nm, ex, got) end
module tb
  import fspg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic                   ref_clk_i;          // Bus clock
  logic                   rst_n_i;            // Sync reset, active low
  logic [FSPG_ADDR_W-1:0] avs_address_i;      // Byte address
  logic                   avs_read_i;         // Read strobe
  logic                   avs_write_i;        // Write strobe
  logic [31:0]            avs_writedata_i;    // Write data
  logic [3:0]             avs_byteenable_i;   // Byte lanes
  logic [31:0]            avs_readdata_o;     // Read data
  logic                   avs_waitrequest_o;  // Slave stall
  fspg_evt_t              evt_i;              // Sequencer pulses
  logic                   op_active_i;        // Operation running
  logic                   launch_ok_o;        // No blocking error
  logic                   seq_abort_o;        // Abort pulse
  logic                   launch_o;           // Launch pulse
  logic                   irq_o;              // Interrupt request
  int                     err_count;          // Mismatches seen
  int                     n_compared;         // Comparisons made
  int                     abort_cnt;          // Abort pulses seen
  int                     launch_cnt;         // Launch pulses seen
  // Event masks, bit order follows the packed struct
  localparam logic [8:0] E_WORD = 9'h100, E_ABORT = 9'h080, E_ILL = 9'h040;
  localparam logic [8:0] E_STOP = 9'h020, E_PROT = 9'h010, E_FREE = 9'h008;
  localparam logic [8:0] E_DONE = 9'h004, E_BLANK = 9'h002, E_DIRTY = 9'h001;
  // Allowed targets per source scenario, bit t set when t is legal
  logic [7:0] allow [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

  fspg_top fspg_top_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .evt_i(evt_i), .op_active_i(op_active_i),
    .launch_ok_o(launch_ok_o), .seq_abort_o(seq_abort_o), .launch_o(launch_o), .irq_o(irq_o));

  // ****************************************
  // Clock and pulse monitors
  // ****************************************
  // Free running bus clock, 100 ns period
  always #50 ref_clk_i = ~ref_clk_i;
  // Count one-cycle output pulses so none slips between reads
  always @(posedge ref_clk_i) begin
    if (seq_abort_o === 1'b1) abort_cnt++;
    if (launch_o === 1'b1) launch_cnt++;
  end

  // ****************************************
  // Bus and event tasks
  // ****************************************
  // One Avalon access; request held until waitrequest seen low
  task automatic acc(input logic w, input logic [3:0] idx, input logic [7:0] d,
                     input logic [3:0] ben, output logic [7:0] q);
    @(posedge ref_clk_i);
    avs_address_i    <= {idx, 2'b00};
    avs_write_i      <= w;
    avs_read_i       <= ~w;
    avs_writedata_i  <= {24'h000000, d};
    avs_byteenable_i <= ben;
    // Sampled at the rising edge, before the design updates its flops
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  // Register write on lane 0
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, 4'h1, q);
  endtask
  // Register read and compare
  task automatic rd(input logic [3:0] idx, input logic [7:0] ex, input string nm);
    logic [7:0] q;
    acc(1'b0, idx, 8'h00, 4'h1, q);
    `CHK(nm, ex, q)
  endtask
  // One-cycle sequencer event
  task automatic pulse(input logic [8:0] m);
    @(posedge ref_clk_i);
    evt_i <= fspg_evt_t'(m);
    @(posedge ref_clk_i);
    evt_i <= '0;
  endtask
  // Synchronous reset, three cycles low
  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask
  // Protection byte for a scenario; bit 6 always written as one
  function automatic logic [7:0] scen(input int s, input logic [1:0] hs, input logic [1:0] ls);
    logic [2:0] b;
    case (s)
      0: b = 3'b011;
      1: b = 3'b001;
      2: b = 3'b010;
      3: b = 3'b000;
      4: b = 3'b100;
      5: b = 3'b101;
      6: b = 3'b110;
      default: b = 3'b111;
    endcase
    return {b[2], 1'b1, b[1], hs, b[0], ls};
  endfunction
  // Verdict; also reached from the watchdog
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v1, v2, ex, q;
    int a0, l0;
    ref_clk_i = 1'b0; rst_n_i = 1'b0; avs_address_i = '0; avs_read_i = 1'b0;
    avs_write_i = 1'b0; avs_writedata_i = '0; avs_byteenable_i = '0; evt_i = '0;
    op_active_i = 1'b0; err_count = 0; n_compared = 0; abort_cnt = 0; launch_cnt = 0;
    // Status access, buffer and completion flags, interrupts
    do_reset();
    rd(FSPG_IDX_PROT, FSPG_PROT_RST, "prot_reset");
    rd(FSPG_IDX_STAT, 8'hc0, "stat_reset");
    a0 = abort_cnt;
    wr(FSPG_IDX_STAT, 8'h36);
    rd(FSPG_IDX_STAT, 8'hc0, "stat_ro_bits");
    `CHK("abort_idle", a0, abort_cnt)
    rd(4'h0, 8'h00, "unmapped");
    acc(1'b1, FSPG_IDX_CNFG, 8'hc0, 4'h0, q);
    rd(FSPG_IDX_CNFG, FSPG_CNFG_RST, "cnfg_no_lane");
    wr(FSPG_IDX_CNFG, 8'hc0);
    `CHKS("irq_be", 1'b1, irq_o)
    wr(FSPG_IDX_STAT, 8'h80);
    rd(FSPG_IDX_STAT, 8'h00, "be_clear");
    `CHKS("irq_off", 1'b0, irq_o)
    pulse(E_FREE);
    rd(FSPG_IDX_STAT, 8'h80, "be_set");
    wr(FSPG_IDX_CNFG, 8'h40);
    `CHKS("irq_be_mask", 1'b0, irq_o)
    pulse(E_DONE);
    rd(FSPG_IDX_STAT, 8'hc0, "cc_set");
    `CHKS("irq_cc", 1'b1, irq_o)
    // Error flags block launch; write one clears, zero keeps
    wr(FSPG_IDX_STAT, 8'h80);
    foreach (allow[i]) if (i < 4) begin
      ex = (i == 0) ? 8'h20 : 8'h10;
      pulse(i == 0 ? E_PROT : i == 1 ? E_ABORT : i == 2 ? E_ILL : E_STOP);
      rd(FSPG_IDX_STAT, ex, "err_set");
      `CHKS("launch_ok_err", 1'b0, launch_ok_o)
      wr(FSPG_IDX_STAT, 8'h00);
      rd(FSPG_IDX_STAT, ex, "err_keep");
      wr(FSPG_IDX_STAT, ex);
      rd(FSPG_IDX_STAT, 8'h00, "err_clear");
      `CHKS("launch_ok_clr", 1'b1, launch_ok_o)
    end
    // Launch clears blank; abort mid-sequence; launch refused on error
    pulse(E_FREE);
    pulse(E_BLANK);
    rd(FSPG_IDX_STAT, 8'h84, "blank_set");
    l0 = launch_cnt;
    a0 = abort_cnt;
    pulse(E_WORD);
    wr(FSPG_IDX_STAT, 8'h80);
    rd(FSPG_IDX_STAT, 8'h00, "launch_stat");
    `CHK("launch_cnt", l0 + 1, launch_cnt)
    pulse(E_FREE);
    pulse(E_WORD);
    wr(FSPG_IDX_STAT, 8'h00);
    rd(FSPG_IDX_STAT, 8'h90, "abort_stat");
    `CHK("abort_cnt", a0 + 1, abort_cnt)
    pulse(E_WORD);
    wr(FSPG_IDX_STAT, 8'h80);
    rd(FSPG_IDX_STAT, 8'h10, "refused_stat");
    `CHK("no_launch", l0 + 1, launch_cnt)
    // Special mode: fail and idle flags
    do_reset();
    wr(FSPG_IDX_CTRL, 8'h01);
    rd(FSPG_IDX_STAT, 8'hc1, "idle_hi");
    op_active_i <= 1'b1;
    rd(FSPG_IDX_STAT, 8'hc0, "idle_lo");
    op_active_i <= 1'b0;
    pulse(E_DIRTY);
    rd(FSPG_IDX_STAT, 8'hc3, "fail_set");
    `CHKS("launch_ok_fail", 1'b0, launch_ok_o)
    wr(FSPG_IDX_STAT, 8'h01);
    rd(FSPG_IDX_STAT, 8'hc3, "fail_keep");
    // Fail cleared before any new sequence
    wr(FSPG_IDX_STAT, 8'h02);
    rd(FSPG_IDX_STAT, 8'hc1, "fail_clear");
    wr(FSPG_IDX_CTRL, 8'h00);
    pulse(E_DIRTY);
    rd(FSPG_IDX_STAT, 8'hc0, "fail_normal");
    // Every source and target scenario, with size field gating
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        do_reset();
        v1 = scen(f, 2'b01, 2'b10);
        wr(FSPG_IDX_PROT, v1);
        rd(FSPG_IDX_PROT, v1, "prot_from");
        v2 = scen(t, 2'b10, 2'b01);
        ex = {v2[7:5], v1[5] ? v2[4:3] : v1[4:3], v2[2], v1[2] ? v2[1:0] : v1[1:0]};
        if (!allow[f][t]) ex = v1;
        wr(FSPG_IDX_PROT, v2);
        rd(FSPG_IDX_PROT, ex, "prot_to");
      end
    end
    complete_run();
  end

  // ****************************************
  // Watchdog
  // ****************************************
  // Whole run needs about 1200 cycles; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    $display("MISMATCH watchdog expected done seen running");
    complete_run();
  end
endmodule
`default_nettype wire
